// ===== verilog/sff_top.sv
// serial frame format block: mode register, tx fifo, transmitter, receiver
// assumes classic wishbone master on clk_i; serial partner on the pins
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sff_cfg.svh"

// ****************************************
// transmit fifo
// ****************************************
module sff_fifo #(
	parameter int W = 8,
	parameter int D = `SFF_FIFO_DEPTH
) (
	input  wire logic         clk_i,     // clock
	input  wire logic         rst_i,     // sync reset
	input  wire logic         in_valid_i, // push request
	output logic              in_ready_o, // space left
	input  wire logic [W-1:0] in_data_i, // push data
	output logic              out_valid_o, // data present
	input  wire logic         out_ready_i, // pop
	output logic [W-1:0]      out_data_o // head data
);
	localparam int AW = $clog2(D);
	if (D < 2 || (1 << AW) != D)
	begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end
	logic [W-1:0] mem [D];
	logic [AW:0]  wr_reg;
	logic [AW:0]  rd_reg;
	assign out_valid_o = wr_reg != rd_reg;
	assign in_ready_o  = (wr_reg ^ rd_reg) != (AW+1)'(D);
	assign out_data_o  = mem[rd_reg[AW-1:0]];
	always_ff @(posedge clk_i)
	begin
		if (in_valid_i && in_ready_o)
			mem[wr_reg[AW-1:0]] <= in_data_i;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wr_reg <= '0;
		else if (in_valid_i && in_ready_o)
			wr_reg <= wr_reg + 1'b1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rd_reg <= '0;
		else if (out_valid_o && out_ready_i)
			rd_reg <= rd_reg + 1'b1;
	end
endmodule : sff_fifo

// ****************************************
// top
// ****************************************
module sff_top
	import sff_pkg::*;
#(
	parameter int FIFO_DEPTH = `SFF_FIFO_DEPTH
) (
	input  wire logic        clk_i,  // 100 MHz clock
	input  wire logic        rst_i,  // sync reset, high
	input  wire logic        cyc_i,  // wishbone cycle
	input  wire logic        stb_i,  // wishbone strobe
	input  wire logic        we_i,   // write
	input  wire logic [7:0]  adr_i,  // byte address
	input  wire logic [3:0]  sel_i,  // byte lanes
	input  wire logic [31:0] dat_i,  // write data
	output logic [31:0]      dat_o,  // read data
	output logic             ack_o,  // acknowledge
	input  wire logic        serial_rx_line_i, // serial data in
	output logic             serial_tx_line_o, // serial data out
	output logic             sclk_o  // sync mode bit clock
);
	import sff_pkg::*;
	if (FIFO_DEPTH < 2)
	begin : g_shallow
		$error("fifo too shallow");
	end

	function automatic logic [3:0] nbits(sff_mode_t m);
		return (m.sync || !m.char_length_select) ? 4'h8 : 4'h7;
	endfunction : nbits
	function automatic logic par_on(sff_mode_t m);
		return m.parity_enable && !m.sync;
	endfunction : par_on

	sff_mode_t   mode_reg;
	logic [15:0] div_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [7:0]  rxd_reg;
	logic [3:0]  flag_reg;
	sff_wb_req_t req;
	logic        take;
	logic        stall;
	logic        fifo_ready;
	logic        fifo_valid;
	logic [7:0]  fifo_data;
	logic        fifo_pop;
	sff_tx_st_t  tx_st_reg;
	logic [15:0] tx_cnt_reg;
	logic [3:0]  tx_bits_reg;
	logic [7:0]  tx_sh_reg;
	logic        tx_par_reg;
	logic        tx_stop_reg;
	logic        tx_reg;
	logic        sclk_reg;
	logic        tx_tick;
	logic        sync_rise;
	logic [2:0]  rx_ff_reg;
	logic        rx_f_reg;
	sff_rx_st_t  rx_st_reg;
	logic [15:0] rx_cnt_reg;
	logic [3:0]  rx_bits_reg;
	logic [7:0]  rx_sh_reg;
	logic        rx_par_reg;
	logic        rx_tick;
	logic        rx_store;
	logic [7:0]  rx_word;
	logic        rx_perr;
	logic        rx_ferr;

// ****************************************
// wishbone slave
// ****************************************
	assign req   = '{cyc_i, stb_i, we_i, adr_i[7:2], sel_i, dat_i};
	assign stall = req.we && req.adr == `SFF_ADR_TXDATA && !fifo_ready;
	// a full fifo holds ack back, so the master is stalled, not dropped
	assign take  = req.cyc && req.stb && !ack_reg && !stall;
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= take;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_reg <= `SFF_MODE_RST;
		else if (take && req.we && req.adr == `SFF_ADR_MODE && req.sel[0])
			mode_reg <= req.dat[7:0];
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			div_reg <= `SFF_DIV_RST;
		else if (take && req.we && req.adr == `SFF_ADR_DIV)
		begin
			if (req.sel[0])
				div_reg[7:0] <= req.dat[7:0];
			if (req.sel[1])
				div_reg[15:8] <= req.dat[15:8];
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_reg <= '0;
		else if (take && !req.we)
			unique case (req.adr)
				`SFF_ADR_MODE:   dat_reg <= {24'h0, mode_reg};
				`SFF_ADR_RXDATA: dat_reg <= {24'h0, rxd_reg};
				`SFF_ADR_STATUS: dat_reg <= {25'h0, tx_st_reg != TX_IDLE, !fifo_ready, !fifo_valid, flag_reg};
				`SFF_ADR_DIV:    dat_reg <= {16'h0, div_reg};
				default:         dat_reg <= '0;
			endcase
	end
	// flags: rx full, parity, framing, overrun; hardware set beats software clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_reg <= '0;
		else
		begin
			logic [3:0] clr;
			clr = '0;
			if (take && req.we && req.adr == `SFF_ADR_STATUS && req.sel[0])
				clr = req.dat[3:0] & 4'(`SFF_ST_W1C);
			if (take && !req.we && req.adr == `SFF_ADR_RXDATA)
				clr[`SFF_ST_RXFULL] = 1'b1;
			flag_reg <= (flag_reg & ~clr) | (rx_store ? {flag_reg[0], rx_ferr, rx_perr, 1'b1} : 4'h0);
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rxd_reg <= '0;
		else if (rx_store)
			rxd_reg <= rx_word;
	end

	sff_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (take && req.we && req.adr == `SFF_ADR_TXDATA && req.sel[0]),
		.in_ready_o  (fifo_ready),
		.in_data_i   (req.dat[7:0]),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

// ****************************************
// transmitter
// ****************************************
	assign tx_tick   = tx_cnt_reg == 16'h0;
	assign fifo_pop  = tx_st_reg == TX_IDLE && fifo_valid;
	// synchronous bit clock rises at mid bit; partner and our receiver sample there
	assign sync_rise = mode_reg.sync && tx_st_reg == TX_DATA && tx_cnt_reg == (div_reg >> 1);
	assign serial_tx_line_o = tx_reg;
	assign sclk_o    = sclk_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || tx_st_reg == TX_IDLE || tx_tick)
			tx_cnt_reg <= rst_i ? 16'h0 : div_reg;
		else
			tx_cnt_reg <= tx_cnt_reg - 1'b1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_st_reg   <= TX_IDLE;
			tx_bits_reg <= '0;
			tx_sh_reg   <= '0;
			tx_par_reg  <= 1'b0;
			tx_stop_reg <= 1'b0;
		end
		else
			unique case (tx_st_reg)
				TX_IDLE:
					if (fifo_valid)
					begin
						// seven-bit characters lose bit 7
						tx_sh_reg   <= nbits(mode_reg) == 4'h7 ? {1'b0, fifo_data[6:0]} : fifo_data;
						tx_par_reg  <= mode_reg.odd;
						tx_bits_reg <= nbits(mode_reg);
						tx_st_reg   <= mode_reg.sync ? TX_DATA : TX_START;
					end
				TX_START:
					if (tx_tick)
						tx_st_reg <= TX_DATA;
				TX_DATA:
					if (tx_tick)
					begin
						tx_sh_reg   <= tx_sh_reg >> 1;
						tx_par_reg  <= tx_par_reg ^ tx_sh_reg[0];
						tx_bits_reg <= tx_bits_reg - 1'b1;
						tx_stop_reg <= mode_reg.stop2;
						if (tx_bits_reg == 4'h1)
							tx_st_reg <= mode_reg.sync ? TX_IDLE : par_on(mode_reg) ? TX_PAR : TX_STOP;
					end
				TX_PAR:
					if (tx_tick)
						tx_st_reg <= TX_STOP;
				TX_STOP:
					if (tx_tick)
					begin
						tx_stop_reg <= 1'b0;
						if (!tx_stop_reg)
							tx_st_reg <= TX_IDLE;
					end
			endcase
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_reg <= 1'b1;
		else
			unique case (tx_st_reg)
				TX_START: tx_reg <= 1'b0;
				TX_DATA:  tx_reg <= tx_sh_reg[0];
				TX_PAR:   tx_reg <= tx_par_reg;
				default:  tx_reg <= 1'b1;
			endcase
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sclk_reg <= 1'b1;
		else
			sclk_reg <= !(mode_reg.sync && tx_st_reg == TX_DATA && tx_cnt_reg > (div_reg >> 1));
	end

// ****************************************
// receiver
// ****************************************
	// three-stage sampler; level changes only when the last two agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_ff_reg <= 3'h7;
		else
			rx_ff_reg <= {rx_ff_reg[1:0], serial_rx_line_i};
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_f_reg <= 1'b1;
		else if (rx_ff_reg[1] == rx_ff_reg[2])
			rx_f_reg <= rx_ff_reg[2];
	end
	assign rx_tick  = rx_cnt_reg == 16'h0;
	// sync: the bit arriving at the last rising clock completes the word
	assign rx_word  = mode_reg.sync ? {rx_f_reg, rx_sh_reg[7:1]} :
		(nbits(mode_reg) == 4'h7 ? rx_sh_reg >> 1 : rx_sh_reg);
	assign rx_store = mode_reg.sync ? (sync_rise && tx_bits_reg == 4'h1) : (rx_st_reg == RX_STOP && rx_tick);
	assign rx_perr  = par_on(mode_reg) && (rx_par_reg != mode_reg.odd);
	assign rx_ferr  = !mode_reg.sync && !rx_f_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i || rx_st_reg == RX_IDLE)
			rx_cnt_reg <= rst_i ? 16'h0 : div_reg >> 1;
		else if (rx_tick)
			rx_cnt_reg <= div_reg;
		else
			rx_cnt_reg <= rx_cnt_reg - 1'b1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_st_reg   <= RX_IDLE;
			rx_bits_reg <= '0;
			rx_sh_reg   <= '0;
			rx_par_reg  <= 1'b0;
		end
		else if (mode_reg.sync)
		begin
			rx_st_reg <= RX_IDLE;
			if (sync_rise)
				rx_sh_reg <= {rx_f_reg, rx_sh_reg[7:1]};
			rx_bits_reg <= 4'h0;
		end
		else
			unique case (rx_st_reg)
				// after the first stop bit the line is watched again, so a low
				// second stop position starts the next character
				RX_IDLE:
					if (!rx_f_reg)
						rx_st_reg <= RX_START;
				RX_START:
					if (rx_tick)
					begin
						rx_st_reg   <= rx_f_reg ? RX_IDLE : RX_DATA;
						rx_bits_reg <= nbits(mode_reg);
						rx_par_reg  <= 1'b0;
					end
				RX_DATA:
					if (rx_tick)
					begin
						rx_sh_reg   <= {rx_f_reg, rx_sh_reg[7:1]};
						rx_par_reg  <= rx_par_reg ^ rx_f_reg;
						rx_bits_reg <= rx_bits_reg - 1'b1;
						if (rx_bits_reg == 4'h1)
							rx_st_reg <= par_on(mode_reg) ? RX_PAR : RX_STOP;
					end
				RX_PAR:
					if (rx_tick)
					begin
						rx_par_reg <= rx_par_reg ^ rx_f_reg;
						rx_st_reg  <= RX_STOP;
					end
				RX_STOP:
					if (rx_tick)
					begin
						rx_bits_reg <= 4'h0;
						rx_st_reg   <= RX_IDLE;
					end
			endcase
	end

// ****************************************
// checks
// ****************************************
	chk_start_low: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(tx_st_reg == TX_START) |=> !serial_tx_line_o) else $error("start bit not low");
	chk_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(tx_st_reg == TX_STOP || tx_st_reg == TX_IDLE) |-> serial_tx_line_o) else $error("stop or idle not high");
	chk_sync_no_par: assert property (@(posedge clk_i) disable iff (rst_i)
		mode_reg.sync && tx_st_reg == TX_DATA |=> tx_st_reg inside {TX_DATA, TX_IDLE}) else $error("sync frame has extras");
	chk_seven_msb: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_st_reg == TX_IDLE && fifo_valid && !mode_reg.sync && mode_reg.char_length_select |=> !tx_sh_reg[7])
		else $error("msb kept");
	chk_data_len: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_st_reg == TX_START && tx_tick |=> tx_bits_reg == (mode_reg.char_length_select ? 4'h7 : 4'h8))
		else $error("wrong length");
	chk_tx_parity: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(tx_st_reg == TX_PAR) |=> serial_tx_line_o == $past(tx_par_reg)) else $error("parity bit wrong");
	chk_mode_wr: assert property (@(posedge clk_i) disable iff (rst_i)
		take && we_i && req.adr == `SFF_ADR_MODE && sel_i[0] |=> ##1 mode_reg == $past(dat_i[7:0], 2)) else $error("mode not written");
	chk_rx_ferr: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_st_reg == RX_STOP && rx_tick && !mode_reg.sync && !rx_f_reg |=> flag_reg[`SFF_ST_FERR]) else $error("framing lost");
	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held");
	cov_async_par: cover property (@(posedge clk_i) disable iff (rst_i) tx_st_reg == TX_PAR);
	cov_two_stop: cover property (@(posedge clk_i) disable iff (rst_i) tx_st_reg == TX_STOP && tx_stop_reg);
	cov_sync_rx: cover property (@(posedge clk_i) disable iff (rst_i) rx_store && mode_reg.sync);
	cov_fifo_full: cover property (@(posedge clk_i) disable iff (rst_i) stall && cyc_i && stb_i);
endmodule : sff_top

// ===== verilog/sff_cfg.svh
// constants of the serial frame format block: offsets, fields, resets, timing
// assumes a 32-bit classic wishbone slave, word addressed through adr_i[7:2]
`ifndef SFF_CFG_SVH
`define SFF_CFG_SVH
// register word indices
`define SFF_ADR_MODE    6'h00
`define SFF_ADR_TXDATA  6'h01
`define SFF_ADR_RXDATA  6'h02
`define SFF_ADR_STATUS  6'h03
`define SFF_ADR_DIV     6'h04
// mode register fields
`define SFF_MODE_SYNC   7
`define SFF_MODE_CHLEN  6
`define SFF_MODE_PAR_EN 5
`define SFF_MODE_ODD    4
`define SFF_MODE_STOP2  3
`define SFF_MODE_RST    8'h00
// status register fields
`define SFF_ST_RXFULL   0
`define SFF_ST_PERR     1
`define SFF_ST_FERR     2
`define SFF_ST_OVR      3
`define SFF_ST_TXEMPTY  4
`define SFF_ST_TXFULL   5
`define SFF_ST_TXBUSY   6
`define SFF_ST_W1C      8'h0F
// bit time: 100 MHz clock, 115200 baud default
`define SFF_CLK_HZ      100000000
`define SFF_BAUD        115200
`define SFF_DIV_RST     16'(`SFF_CLK_HZ / `SFF_BAUD - 1)
`define SFF_FIFO_DEPTH  16
`endif

// ===== verilog/sff_pkg.sv
// types of the serial frame format block
// assumes sff_cfg.svh for all numeric constants
package sff_pkg;
	typedef struct packed {
		logic       sync;      // 1: clock synchronous
		logic       char_length_select; // 1: seven data bits, async mode only
		logic       parity_enable;      // parity on, async mode only
		logic       odd;       // 1: odd parity
		logic       stop2;     // two stop bits, async mode only
		logic [2:0] rsv;
	} sff_mode_t;
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [5:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sff_wb_req_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} sff_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} sff_rx_st_t;
endpackage : sff_pkg

// ===== tb/sff_far_end.sv
// far-end serial device: drives the rx line, captures tx frames
// assumes tasks are entered on a rising clk_i edge; a bit lasts BT clocks
`timescale 1ns/1ps
module sff_far_end #(
	parameter int BT = 4
) (
	input  wire logic clk_i,            // clock
	input  wire logic serial_tx_line_i, // from block
	input  wire logic sclk_i,           // sync bit clock
	output logic      serial_rx_line_o  // to block
);
	initial serial_rx_line_o = 1'b1; // idle high
	task automatic bit_out(input logic v);
		serial_rx_line_o <= v;
		repeat (BT) @(posedge clk_i);
	endtask : bit_out
	// a low stop value makes a framing fault; line released high after it
	task automatic send(input logic [7:0] d, input int nb, input bit par_en, input logic pb, input logic sv);
		bit_out(1'b0);
		for (int i = 0; i < nb; i++)
			bit_out(d[i]);
		if (par_en)
			bit_out(pb);
		bit_out(sv);
		if (sv !== 1'b1)
			serial_rx_line_o <= 1'b1;
	endtask : send
	// hi: high clocks after the last bit, up to the next start
	task automatic grab(input int nb, input bit par_en, output logic [7:0] d, output logic p, output logic st,
		output int hi);
		d = 8'h00;
		p = 1'b0;
		for (int k = 0; serial_tx_line_i !== 1'b0 && k < 3000; k++) @(posedge clk_i);
		repeat (BT / 2) @(posedge clk_i);
		st = serial_tx_line_i;
		for (int i = 0; i < nb; i++)
		begin
			repeat (BT) @(posedge clk_i);
			d[i] = serial_tx_line_i;
		end
		if (par_en)
		begin
			repeat (BT) @(posedge clk_i);
			p = serial_tx_line_i;
		end
		repeat (BT / 2) @(posedge clk_i);
		for (hi = 0; serial_tx_line_i === 1'b1 && hi < 40; hi++) @(posedge clk_i);
	endtask : grab
	task automatic sgrab(output logic [7:0] d);
		for (int i = 0; i < 8; i++)
		begin
			for (int j = 0; sclk_i !== 1'b0 && j < 3000; j++) @(posedge clk_i);
			for (int j = 0; sclk_i !== 1'b1 && j < 3000; j++) @(posedge clk_i);
			d[i] = serial_tx_line_i;
		end
	endtask : sgrab
endmodule : sff_far_end

// ===== tb/test_serial_frame_format_config.sv
// self-checking bench of the serial frame format block
// assumes sff_top and the far-end model; wishbone master driven here
`timescale 1ns/1ps
`include "sff_cfg.svh"
module test_serial_frame_format_config;
	localparam int BT = 4;
	localparam int LIMIT = 40000;
	localparam logic [7:0] TXM [7] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h58, 8'h28, 8'h10};
	localparam logic [7:0] RXM [8] = '{8'h00, 8'h20, 8'h20, 8'h30, 8'h30, 8'h40, 8'h10, 8'h00};
	localparam logic [7:0] RXD [8] = '{8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'hDA, 8'h5A, 8'h5A};
	localparam logic       RXP [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	localparam logic       RXS [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	localparam logic [31:0] RXE [8] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h2, 32'h0, 32'h0, 32'h4};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        txl;
	logic        rxl;
	logic        sclk;
	logic [31:0] r;
	logic [7:0]  d;
	logic [7:0]  m;
	logic [7:0]  mask;
	logic        p;
	logic        st;
	int          hi;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cyc_cnt = 0;
	always #5 clk_i = ~clk_i;
	sff_top u_sff_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .serial_rx_line_i(rxl),
		.serial_tx_line_o(txl), .sclk_o(sclk));
	sff_far_end #(.BT(BT)) u_sff_far_end (.clk_i(clk_i), .serial_tx_line_i(txl), .sclk_i(sclk),
		.serial_rx_line_o(rxl));
	// ****************************************
	// tasks
	// ****************************************
	task automatic give_verdict;
		if (n_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_cnt(input int got, input int exp);
		n_compared++;
		if (got != exp)
		begin
			n_errors++;
			$display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt
	// classic cycle: raise, hold until ack is sampled, then drop
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= wd;
		@(posedge clk_i);
		for (k = 0; ack_o !== 1'b1 && k < 3000; k++) @(posedge clk_i);
		chk_cnt(k < 3000, 1);
		rdat = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		wb(1'b1, a, wd, x);
	endtask : wr
	task automatic poll_rx(output logic [31:0] s);
		s = 32'h0;
		for (int k = 0; k < 100 && s[0] !== 1'b1; k++)
			wb(1'b0, 8'h0C, 32'h0, s);
	endtask : poll_rx
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == LIMIT)
		begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			give_verdict();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0, r);
		chk_val(r, 32'h0);
		wb(1'b0, 8'h10, 32'h0, r);
		chk_val(r, {16'h0, `SFF_DIV_RST});
		wr(8'h00, 32'hA5);
		wb(1'b0, 8'h00, 32'h0, r);
		chk_val(r, 32'hA5);
		wb(1'b0, 8'h1C, 32'h0, r);
		chk_val(r, 32'h0);
		wr(8'h10, 32'h3);
		foreach (TXM[i])
		begin
			m = TXM[i];
			mask = m[6] ? 8'h7F : 8'hFF;
			wr(8'h00, {24'h0, m});
			fork
				begin
					u_sff_far_end.grab(m[6] ? 7 : 8, m[5], d, p, st, hi);
					chk_val({24'h0, d}, {24'h0, 8'hB5 & mask});
					chk_val(32'(st), 32'h0);
					if (m[5])
						chk_val(32'(p), 32'(^(8'hB5 & mask) ^ m[4]));
					chk_cnt((hi + 1) / BT, m[3] ? 2 : 1);
					u_sff_far_end.grab(m[6] ? 7 : 8, m[5], d, p, st, hi);
					chk_val({24'h0, d}, {24'h0, 8'h4A & mask});
				end
				begin
					wr(8'h04, 32'hB5);
					wr(8'h04, 32'h4A);
				end
			join
		end
		foreach (RXM[i])
		begin
			m = RXM[i];
			wr(8'h00, {24'h0, m});
			wr(8'h0C, 32'hF);
			u_sff_far_end.send(RXD[i], m[6] ? 7 : 8, m[5], RXP[i], RXS[i]);
			poll_rx(r);
			chk_val(r & 32'h6, RXE[i]);
			wb(1'b0, 8'h08, 32'h0, r);
			chk_val(r, {24'h0, RXD[i] & (m[6] ? 8'h7F : 8'hFF)});
		end
		wr(8'h00, 32'h28);
		wr(8'h0C, 32'hF);
		fork
			begin
				u_sff_far_end.send(8'h11, 8, 1'b1, 1'b0, 1'b1);
				u_sff_far_end.send(8'h22, 8, 1'b1, 1'b0, 1'b1);
			end
			begin
				poll_rx(r);
				wb(1'b0, 8'h08, 32'h0, r);
				chk_val(r, 32'h11);
				poll_rx(r);
				chk_val(r & 32'h6, 32'h0);
				wb(1'b0, 8'h08, 32'h0, r);
				chk_val(r, 32'h22);
			end
		join
		wr(8'h00, 32'hF8);
		fork
			begin
				u_sff_far_end.sgrab(d);
				chk_val({24'h0, d}, 32'hB5);
				u_sff_far_end.sgrab(d);
				chk_val({24'h0, d}, 32'h3C);
			end
			begin
				wr(8'h04, 32'hB5);
				wr(8'h04, 32'h3C);
			end
		join
		// idle-high rx line clocked in eight times gives all ones
		wb(1'b0, 8'h08, 32'h0, r);
		chk_val(r, 32'hFF);
		repeat (20) @(posedge clk_i);
		wr(8'h00, 32'h0);
		wr(8'h10, 32'h63);
		// one word beyond fifo and shifter stalls the bus until a frame ends
		repeat (18) wr(8'h04, 32'h55);
		wb(1'b0, 8'h0C, 32'h0, r);
		chk_val(r & 32'h30, 32'h20);
		for (int k = 0; k < 300 && (r & 32'h70) !== 32'h10; k++)
		begin
			repeat (100) @(posedge clk_i);
			wb(1'b0, 8'h0C, 32'h0, r);
		end
		chk_val(r & 32'h70, 32'h10);
		give_verdict();
	end
endmodule : test_serial_frame_format_config
